// ---- hdl/brgp_pkg.sv ----
// Behaviour
// - remap enable bit 3 connects on-board request/ack pair to chosen ISA channel
// - channel code 000-011 gives 0-3, 100 disables, 101-111 give 5-7
// - drive interrupt remapped when bit 7 is 0; codes 0-2, 8, 13 reserved
// - interrupt remap bits 6:4 read as zero
// - pin control bit 7: 0 output, 1 input; resets to input
// - pin control bit 6: 0 active low input, 1 active high input
// - pin control bit 5 routes pin input through the debounce filter
// - debounce interval is (count - 1) times 0.6 s; software uses count >= 2
// - arbiter enable bit 7 resets to 1; 0 stops the drive bus master
// - arbiter enable bits 6:0 read as zero
// - pin driven low for subtractive I/O cycle matching base in bits 15:2
// - decode output only in output mode; never driven in input mode
// - mask 00 ignores A1-0, 01 A2-0, 11 A3-0, 10 disables decode
// - status bit 4 picks fixed (0) or rotating (1) arbiter priority
// - status bit 2 read-only, shows real-time clock in use
// - status bit 0 sets when pin becomes active, held until software clears
// - edge/level bits 7:3 select edge (0) or level (1) for IRQ7..IRQ3
// - edge/level bits 2:0 read 0; software writes only 0
// - edge/level register resets to zero, all lines edge sensitive
// - ISA request/ack pins masked for channel owned by on-board pair
package brgp_pkg;

  // configuration space offsets
  localparam logic [7:0]  DMA_REMAP_OFS   = 8'h62;
  localparam logic [7:0]  IRQ_REMAP_OFS   = 8'h63;
  localparam logic [7:0]  PIN_CTRL_OFS    = 8'h64;
  localparam logic [7:0]  ARB_EN_OFS      = 8'h65;
  localparam logic [7:0]  DEC_LO_OFS      = 8'h66;
  localparam logic [7:0]  DEC_HI_OFS      = 8'h67;
  localparam logic [7:0]  STATUS_OFS      = 8'h6a;
  // i/o space offset
  localparam logic [15:0] IRQ_SENSE_OFS   = 16'h04d0;

  // reset values
  localparam logic [7:0]  DMA_REMAP_RST   = 8'h00;
  localparam logic [7:0]  IRQ_REMAP_RST   = 8'h80;
  localparam logic [7:0]  PIN_CTRL_RST    = 8'h80;
  localparam logic [7:0]  ARB_EN_RST      = 8'h80;
  localparam logic [15:0] DEC_RST         = 16'h0000;
  localparam logic [7:0]  STATUS_RST      = 8'h00;
  localparam logic [7:0]  IRQ_SENSE_RST   = 8'h00;

  // field positions
  localparam int DMA_EN_BIT    = 3;
  localparam int IRQ_DIS_BIT   = 7;
  localparam int PIN_DIR_BIT   = 7;
  localparam int PIN_POL_BIT   = 6;
  localparam int PIN_DEB_BIT   = 5;
  localparam int ARB_EN_BIT    = 7;
  localparam int ARB_ROT_BIT   = 4;
  localparam int ST_RSV3_BIT   = 3;
  localparam int ST_RTC_BIT    = 2;
  localparam int ST_PIN_BIT    = 0;

  // writable masks per register
  localparam logic [7:0]  DMA_REMAP_WMASK = 8'hff;
  localparam logic [7:0]  IRQ_REMAP_WMASK = 8'h8f;
  localparam logic [7:0]  PIN_CTRL_WMASK  = 8'hef;
  localparam logic [7:0]  ARB_EN_WMASK    = 8'h80;
  localparam logic [7:0]  STATUS_WMASK    = 8'h18;
  localparam logic [7:0]  IRQ_SENSE_WMASK = 8'hf8;

  // channel code that switches the remap off
  localparam logic [2:0]  DMA_CODE_OFF    = 3'h4;

  // decode mask codes
  localparam logic [1:0]  MASK_A1_0       = 2'h0;
  localparam logic [1:0]  MASK_A2_0       = 2'h1;
  localparam logic [1:0]  MASK_OFF        = 2'h2;
  localparam logic [1:0]  MASK_A3_0       = 2'h3;

  // debounce tick timing
  localparam longint CLK_HZ     = 25_000_000;
  localparam longint TICK_MS    = 600;
  localparam longint TICK_CYC   = CLK_HZ * TICK_MS / 1000;

endpackage

// ---- hdl/brgp_tick.sv ----
`timescale 1ns/1ns
`default_nettype none
// divider for the slow debounce tick
module brgp_tick
  import brgp_pkg::*;
#(
  parameter int TICK_CYCLES = int'(TICK_CYC)
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // tick
  output logic      tick
);

  logic [31:0] cnt_r;

  initial begin
    if (TICK_CYCLES < 1) begin
      $error("brgp_tick: TICK_CYCLES must be at least 1");
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_r == 32'(TICK_CYCLES - 1)) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/brgp_debounce.sv ----
`timescale 1ns/1ns
`default_nettype none
// filtered level follows raw only after it held for (count - 1) ticks
module brgp_debounce #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] count,
  // levels
  input  wire logic             raw,
  output logic                  filt
);

  logic [CNT_W-1:0] ticks_r;
  logic [CNT_W-1:0] limit;

  initial begin
    if (CNT_W < 2) begin
      $error("brgp_debounce: CNT_W must be at least 2");
    end
  end

  // counts below 2 are illegal; treat as one tick rather than stall
  assign limit = (count < CNT_W'(2)) ? CNT_W'(1) : count - CNT_W'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks_r <= '0;
      filt    <= 1'b0;
    end else if (raw == filt) begin
      ticks_r <= '0;
    end else if (tick) begin
      if (ticks_r + CNT_W'(1) >= limit) begin
        filt    <= raw;
        ticks_r <= '0;
      end else begin
        ticks_r <= ticks_r + CNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// ---- hdl/brgp_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module brgp_top
  import brgp_pkg::*;
#(
  parameter int TICK_CYCLES = int'(TICK_CYC),
  parameter int DEB_W       = 4
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,

  // configuration cycles, byte wide
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output logic [7:0]       cfg_rdata,
  output logic             cfg_rvalid,

  // pci i/o cycles, byte wide
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        io_subtractive,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  output logic             io_rvalid,

  // on-board dma pair
  input  wire logic        onboard_dma_request_0,
  output logic             onboard_dma_ack_0_n,

  // isa dma pins
  input  wire logic [7:0]  isa_dreq,
  output logic [7:0]       isa_dack_n,

  // dma controller side
  output logic [7:0]       dmac_dreq,
  input  wire logic [7:0]  dmac_dack_n,

  // interrupts
  input  wire logic        drive_ctrl_interrupt,
  input  wire logic [15:0] isa_irq,
  output logic [15:0]      pic_irq,
  output logic             drive_irq_direct,
  output logic [7:0]       irq_level_sense,

  // arbiter control
  output logic             arb_enable,
  output logic             arb_rotate,
  output logic             drive_master_allow,

  // real-time clock status
  input  wire logic        rtc_in_use,

  // general pin, three signals, and its event flag
  input  wire logic        general_pin_zero_in,
  output logic             general_pin_zero_out,
  output logic             general_pin_zero_oe_n,
  output logic             pin_event
);

  // register state
  logic [7:0]       dma_remap_r;
  logic [7:0]       irq_remap_r;
  logic [7:0]       pin_ctrl_r;
  logic [7:0]       arb_en_r;
  logic [15:0]      dec_r;
  logic [7:0]       status_r;
  logic [7:0]       irq_sense_r;

  // pin path
  logic             tick;
  logic             pin_raw;
  logic             pin_filt;
  logic             pin_level;
  logic             pin_level_r;
  logic             pin_rise;
  logic             dec_hit;

  // routing
  logic             dma_on;
  logic [2:0]       dma_ch;
  logic             irq_on;
  logic [3:0]       irq_num;
  logic [7:0]       dreq_nxt;
  logic [7:0]       isa_dack_nxt;
  logic             ob_ack_nxt;
  logic [15:0]      pic_nxt;

  // write and read strobes
  logic             cfg_wr_dma;
  logic             cfg_wr_irq;
  logic             cfg_wr_pin;
  logic             cfg_wr_arb;
  logic             cfg_wr_dlo;
  logic             cfg_wr_dhi;
  logic             cfg_wr_st;
  logic             io_wr_sense;
  logic [7:0]       cfg_rd_nxt;

  initial begin
    if (DEB_W != 4) begin
      $error("brgp_top: DEB_W must be 4, the count field width");
    end
    if (TICK_CYCLES < 1) begin
      $error("brgp_top: TICK_CYCLES must be at least 1");
    end
  end

  // channel code to on/off and channel number
  function automatic logic dma_code_on(input logic [7:0] r);
    dma_code_on = r[DMA_EN_BIT] && (r[2:0] != DMA_CODE_OFF);
  endfunction

  // interrupt code validity: 3-7, 9-12, 14, 15
  function automatic logic irq_code_ok(input logic [3:0] c);
    case (c)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h9, 4'ha, 4'hb, 4'hc,
      4'he, 4'hf: irq_code_ok = 1'b1;
      default:    irq_code_ok = 1'b0;
    endcase
  endfunction

  // address compare with low bits ignored as the mask field says
  function automatic logic dec_match(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] keep;
    keep = 16'h0000;
    case (d[1:0])
      MASK_A1_0: keep = 16'hfffc;
      MASK_A2_0: keep = 16'hfff8;
      MASK_A3_0: keep = 16'hfff0;
      default:   keep = 16'h0000;
    endcase
    dec_match = (d[1:0] != MASK_OFF) &&
                ((a & keep) == ({d[15:2], 2'b00} & keep));
  endfunction

  assign cfg_wr_dma  = cfg_wr && (cfg_addr == DMA_REMAP_OFS);
  assign cfg_wr_irq  = cfg_wr && (cfg_addr == IRQ_REMAP_OFS);
  assign cfg_wr_pin  = cfg_wr && (cfg_addr == PIN_CTRL_OFS);
  assign cfg_wr_arb  = cfg_wr && (cfg_addr == ARB_EN_OFS);
  assign cfg_wr_dlo  = cfg_wr && (cfg_addr == DEC_LO_OFS);
  assign cfg_wr_dhi  = cfg_wr && (cfg_addr == DEC_HI_OFS);
  assign cfg_wr_st   = cfg_wr && (cfg_addr == STATUS_OFS);
  assign io_wr_sense = io_wr && (io_addr == IRQ_SENSE_OFS);

  // dma remap register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_remap_r <= DMA_REMAP_RST;
    end else if (cfg_wr_dma) begin
      dma_remap_r <= cfg_wdata & DMA_REMAP_WMASK;
    end
  end

  // interrupt remap register, middle bits held at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_remap_r <= IRQ_REMAP_RST;
    end else if (cfg_wr_irq) begin
      irq_remap_r <= cfg_wdata & IRQ_REMAP_WMASK;
    end
  end

  // pin control, reserved bit 4 held at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_ctrl_r <= PIN_CTRL_RST;
    end else if (cfg_wr_pin) begin
      pin_ctrl_r <= cfg_wdata & PIN_CTRL_WMASK;
    end
  end

  // arbiter enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_en_r <= ARB_EN_RST;
    end else if (cfg_wr_arb) begin
      arb_en_r <= cfg_wdata & ARB_EN_WMASK;
    end
  end

  // decode base and mask, two byte lanes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_r <= DEC_RST;
    end else begin
      if (cfg_wr_dlo) begin
        dec_r[7:0] <= cfg_wdata;
      end
      if (cfg_wr_dhi) begin
        dec_r[15:8] <= cfg_wdata;
      end
    end
  end

  // status: mode bits by write, pin flag sticky with set over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= STATUS_RST;
    end else begin
      if (cfg_wr_st) begin
        status_r[ARB_ROT_BIT] <= cfg_wdata[ARB_ROT_BIT];
        status_r[ST_RSV3_BIT] <= cfg_wdata[ST_RSV3_BIT];
      end
      if (pin_rise) begin
        status_r[ST_PIN_BIT] <= 1'b1;
      end else if (cfg_wr_st && cfg_wdata[ST_PIN_BIT]) begin
        status_r[ST_PIN_BIT] <= 1'b0;
      end
    end
  end

  // edge/level register, low three bits never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sense_r <= IRQ_SENSE_RST;
    end else if (io_wr_sense) begin
      irq_sense_r <= io_wdata & IRQ_SENSE_WMASK;
    end
  end

  // configuration read mux
  always_comb begin
    cfg_rd_nxt = 8'h00;
    case (cfg_addr)
      DMA_REMAP_OFS: cfg_rd_nxt = dma_remap_r;
      IRQ_REMAP_OFS: cfg_rd_nxt = irq_remap_r;
      PIN_CTRL_OFS:  cfg_rd_nxt = pin_ctrl_r;
      ARB_EN_OFS:    cfg_rd_nxt = arb_en_r;
      DEC_LO_OFS:    cfg_rd_nxt = dec_r[7:0];
      DEC_HI_OFS:    cfg_rd_nxt = dec_r[15:8];
      STATUS_OFS: begin
        cfg_rd_nxt = status_r;
        cfg_rd_nxt[ST_RTC_BIT] = rtc_in_use;
      end
      default:       cfg_rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata  <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= cfg_rd_nxt;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata  <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd && (io_addr == IRQ_SENSE_OFS);
      if (io_rd) begin
        io_rdata <= (io_addr == IRQ_SENSE_OFS) ? irq_sense_r : 8'h00;
      end
    end
  end

  // dma routing
  assign dma_on = dma_code_on(dma_remap_r);
  assign dma_ch = dma_remap_r[2:0];

  always_comb begin
    dreq_nxt     = isa_dreq;
    isa_dack_nxt = dmac_dack_n;
    ob_ack_nxt   = 1'b1;
    if (dma_on) begin
      dreq_nxt[dma_ch]     = onboard_dma_request_0;
      isa_dack_nxt[dma_ch] = 1'b1;
      ob_ack_nxt           = dmac_dack_n[dma_ch];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmac_dreq           <= 8'h00;
      isa_dack_n          <= 8'hff;
      onboard_dma_ack_0_n <= 1'b1;
    end else begin
      dmac_dreq           <= dreq_nxt;
      isa_dack_n          <= isa_dack_nxt;
      onboard_dma_ack_0_n <= ob_ack_nxt;
    end
  end

  // interrupt routing; the drive line shares the chosen input
  assign irq_on  = !irq_remap_r[IRQ_DIS_BIT] && irq_code_ok(irq_remap_r[3:0]);
  assign irq_num = irq_remap_r[3:0];

  always_comb begin
    pic_nxt = isa_irq;
    if (irq_on) begin
      pic_nxt[irq_num] = isa_irq[irq_num] | drive_ctrl_interrupt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pic_irq          <= 16'h0000;
      drive_irq_direct <= 1'b0;
    end else begin
      pic_irq          <= pic_nxt;
      drive_irq_direct <= irq_on ? 1'b0 : drive_ctrl_interrupt;
    end
  end

  // arbiter and sense controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_enable         <= ARB_EN_RST[ARB_EN_BIT];
      drive_master_allow <= ARB_EN_RST[ARB_EN_BIT];
      arb_rotate         <= STATUS_RST[ARB_ROT_BIT];
      irq_level_sense    <= IRQ_SENSE_RST;
    end else begin
      arb_enable         <= arb_en_r[ARB_EN_BIT];
      drive_master_allow <= arb_en_r[ARB_EN_BIT];
      arb_rotate         <= status_r[ARB_ROT_BIT];
      irq_level_sense    <= irq_sense_r;
    end
  end

  // pin input path: polarity first, then optional filter
  assign pin_raw = pin_ctrl_r[PIN_POL_BIT] ? general_pin_zero_in
                                           : !general_pin_zero_in;

  brgp_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  brgp_debounce #(
    .CNT_W (DEB_W)
  ) u_deb (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick),
    .count (pin_ctrl_r[DEB_W-1:0]),
    .raw   (pin_raw),
    .filt  (pin_filt)
  );

  assign pin_level = pin_ctrl_r[PIN_DEB_BIT] ? pin_filt : pin_raw;
  // only an input pin can raise the flag; own decode pulses are ignored
  assign pin_rise  = pin_ctrl_r[PIN_DIR_BIT] && pin_level && !pin_level_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level_r <= 1'b0;
      pin_event   <= 1'b0;
    end else begin
      pin_level_r <= pin_level;
      pin_event   <= status_r[ST_PIN_BIT];
    end
  end

  // output decode, one low cycle per matching subtractive cycle
  assign dec_hit = !pin_ctrl_r[PIN_DIR_BIT] && io_subtractive && (io_rd || io_wr) &&
                   dec_match(io_addr, dec_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      general_pin_zero_out  <= 1'b1;
      general_pin_zero_oe_n <= 1'b1;
    end else begin
      general_pin_zero_oe_n <= pin_ctrl_r[PIN_DIR_BIT];
      general_pin_zero_out  <= !dec_hit;
    end
  end

endmodule
`default_nettype wire

// ---- tb/brgp_top_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module brgp_top_sva #(
  parameter int TICK_CYCLES = 4,
  parameter int DEB_W       = 4
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // bus cycles
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [7:0]  cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic        io_subtractive,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_rvalid,
  // device side
  input wire logic        rtc_in_use,
  input wire logic        onboard_dma_ack_0_n,
  input wire logic [7:0]  dmac_dack_n,
  input wire logic [7:0]  irq_level_sense,
  input wire logic        arb_enable,
  input wire logic        drive_master_allow,
  input wire logic        general_pin_zero_out,
  input wire logic        general_pin_zero_oe_n,
  input wire logic        pin_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_irq_rsv_zero: assert property (cfg_rd && cfg_addr == 8'h63 |=> cfg_rdata[6:4] == 3'h0)
    else $error("irq remap reserved bits not zero");
  a_arb_rsv_zero: assert property (cfg_rd && cfg_addr == 8'h65 |=>
    cfg_rdata[6:0] == 7'h00)
    else $error("arbiter reserved bits not zero");
  a_rtc_status: assert property (cfg_rd && cfg_addr == 8'h6a |=>
    cfg_rdata[2] == $past(rtc_in_use))
    else $error("rtc status bit wrong");
  a_arb_read: assert property (cfg_rd && cfg_addr == 8'h65 |=>
    cfg_rdata[7] == drive_master_allow)
    else $error("drive master allow differs from arbiter enable bit");
  a_flag_read: assert property (cfg_rd && cfg_addr == 8'h6a |=>
    pin_event == cfg_rdata[0])
    else $error("pin event differs from status flag");
  a_cfg_rvalid: assert property (cfg_rvalid == $past(cfg_rd))
    else $error("config read valid not one cycle after strobe");
  a_io_rvalid: assert property (io_rvalid == $past(io_rd && io_addr == 16'h04d0))
    else $error("io read valid wrong");
  a_sense_low_zero: assert property (irq_level_sense[2:0] == 3'h0)
    else $error("sense bits 2:0 not zero");
  a_sense_write: assert property (io_wr && io_addr == 16'h04d0 |=> ##1
    irq_level_sense == ($past(io_wdata, 2) & 8'hf8))
    else $error("sense output does not follow write");
  a_arb_allow: assert property (drive_master_allow == arb_enable)
    else $error("drive master allowed while arbiter off");
  a_input_no_drive: assert property (general_pin_zero_oe_n |-> general_pin_zero_out)
    else $error("pin driven low in input mode");
  a_decode_cause: assert property ($fell(general_pin_zero_out) |->
    $past(io_subtractive && (io_rd || io_wr) && !general_pin_zero_oe_n))
    else $error("pin low without subtractive cycle");
  a_dma_ack_route: assert property ($fell(onboard_dma_ack_0_n) |->
    $past(dmac_dack_n) != 8'hff)
    else $error("onboard ack without controller ack");

  c_read: cover property (cfg_rvalid);
  c_decode: cover property ($fell(general_pin_zero_out));
  c_flag: cover property ($rose(pin_event));
endmodule

bind brgp_top brgp_top_sva #(.TICK_CYCLES(TICK_CYCLES), .DEB_W(DEB_W)) u_sva (
  .clk(clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .io_wr(io_wr), .io_rd(io_rd), .io_subtractive(io_subtractive),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_rvalid(io_rvalid), .rtc_in_use(rtc_in_use),
  .onboard_dma_ack_0_n(onboard_dma_ack_0_n), .dmac_dack_n(dmac_dack_n),
  .irq_level_sense(irq_level_sense), .arb_enable(arb_enable),
  .drive_master_allow(drive_master_allow), .general_pin_zero_out(general_pin_zero_out),
  .general_pin_zero_oe_n(general_pin_zero_oe_n), .pin_event(pin_event));
`default_nettype wire

// ---- tb/brgp_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// pci host: one strobe per cycle, launched 1 ns after the edge
module brgp_host (
  // clock
  input wire logic        clk,
  // config cycles
  output logic            cfg_wr,
  output logic            cfg_rd,
  output logic [7:0]      cfg_addr,
  output logic [7:0]      cfg_wdata,
  input wire logic [7:0]  cfg_rdata,
  // i/o cycles
  output logic            io_wr,
  output logic            io_rd,
  output logic            io_subtractive,
  output logic [15:0]     io_addr,
  output logic [7:0]      io_wdata,
  input wire logic [7:0]  io_rdata
);
  initial begin
    {cfg_wr, cfg_rd, io_wr, io_rd, io_subtractive} = 5'h0;
    {cfg_addr, cfg_wdata, io_wdata} = 24'h0;
    io_addr = 16'h0000;
  end

  task automatic cfg(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    #1;
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_wdata = (a == 8'h6a) ? (d & 8'hf7) : d;
    @(posedge clk);
    #1;
    q = cfg_rdata;
    {cfg_wr, cfg_rd} = 2'h0;
    // released bus does not keep its last value
    cfg_addr = ~cfg_addr;
    cfg_wdata = ~cfg_wdata;
  endtask

  task automatic io(input logic w, s, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clk);
    #1;
    io_wr = w;
    io_rd = !w;
    io_subtractive = s;
    io_addr = a;
    io_wdata = (a == 16'h04d0) ? (d & 8'hf8) : d;
    @(posedge clk);
    #1;
    q = io_rdata;
    {io_wr, io_rd, io_subtractive} = 3'h0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask
endmodule
`default_nettype wire

// ---- tb/brgp_top_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module brgp_top_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cfg_wr, cfg_rd, cfg_rvalid, io_wr, io_rd, io_sub, io_rvalid, hit;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, io_wdata, io_rdata, q, e;
  logic [15:0] io_addr, isa_irq, pic_irq, a, msk;
  logic        req, ack_n, drv, direct, arb_en, arb_rot, allow, rtc, pin_in, pin_out, oe_n, ev;
  logic [7:0]  isa_dreq, isa_dack_n, dmac_dreq, dmac_dack_n, sense;
  logic [7:0]  ofs [8] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h6a};
  logic [7:0]  rv [8] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] adr [4] = '{16'h1233, 16'h1237, 16'h123f, 16'h1230};
  int          miscompares = 0;
  int          tests_run = 0;

  always #20 clk = ~clk;

  brgp_host u_host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_subtractive(io_sub), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

  brgp_top #(.TICK_CYCLES(4), .DEB_W(4)) u_dut (.clk(clk), .rst_n(rst_n),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .io_wr(io_wr), .io_rd(io_rd),
    .io_subtractive(io_sub), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .onboard_dma_request_0(req), .onboard_dma_ack_0_n(ack_n),
    .isa_dreq(isa_dreq), .isa_dack_n(isa_dack_n), .dmac_dreq(dmac_dreq),
    .dmac_dack_n(dmac_dack_n), .drive_ctrl_interrupt(drv), .isa_irq(isa_irq),
    .pic_irq(pic_irq), .drive_irq_direct(direct), .irq_level_sense(sense),
    .arb_enable(arb_en), .arb_rotate(arb_rot), .drive_master_allow(allow),
    .rtc_in_use(rtc), .general_pin_zero_in(pin_in), .general_pin_zero_out(pin_out),
    .general_pin_zero_oe_n(oe_n), .pin_event(ev));

  task automatic chk_reg(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_sig(input logic [16:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: pins got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] ad, d);
    u_host.cfg(1'b1, ad, d, q);
  endtask

  task automatic rdc(input logic [7:0] ad, exp);
    u_host.cfg(1'b0, ad, 8'h00, q);
    chk_reg(q, exp);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    miscompares++;
    test_done();
  end

  initial begin
    {req, drv, rtc} = 3'h0;
    pin_in = 1'b1;
    isa_dreq = 8'h00;
    dmac_dack_n = 8'hff;
    isa_irq = 16'h0028;
    cyc(10);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) rdc(ofs[i], rv[i]);
    chk_sig({allow, arb_en, arb_rot, oe_n, pin_out}, 17'h1b);
    u_host.io(1'b0, 1'b0, 16'h04d0, 8'h00, q);
    chk_reg(q, 8'h00);
    // reserved and read-only bits
    wr(8'h63, 8'hff);
    rdc(8'h63, 8'h8f);
    wr(8'h64, 8'h90);
    rdc(8'h64, 8'h80);
    wr(8'h65, 8'h7f);
    rdc(8'h65, 8'h00);
    chk_sig({allow, arb_en}, 17'h0);
    wr(8'h65, 8'h80);
    rtc = 1'b1;
    wr(8'h6a, 8'hff);
    rdc(8'h6a, 8'h14);
    chk_sig(arb_rot, 17'h1);
    rtc = 1'b0;
    wr(8'h6a, 8'h00);
    rdc(8'h6a, 8'h00);
    // edge/level sense
    for (int i = 3; i < 9; i++) begin
      e = (i < 8) ? (8'h01 << i) : 8'hff;
      u_host.io(1'b1, 1'b0, 16'h04d0, e, q);
      u_host.io(1'b0, 1'b0, 16'h04d0, 8'h00, q);
      chk_reg(q, e & 8'hf8);
      chk_reg(sense, e & 8'hf8);
    end
    // dma remap over every channel code, then enable off
    for (int c = 0; c < 9; c++) begin
      wr(8'h62, (c < 8) ? {5'b00001, c[2:0]} : 8'h01);
      req = 1'b1;
      isa_dreq = 8'h00;
      e = (c < 8 && c != 4) ? (8'h01 << c) : 8'h00;
      cyc(2);
      chk_sig(dmac_dreq, e);
      req = 1'b0;
      isa_dreq = 8'hff;
      dmac_dack_n = ~e;
      cyc(2);
      chk_sig({ack_n, dmac_dreq, isa_dack_n}, {e == 8'h00, ~e, 8'hff});
      dmac_dack_n = 8'hff;
    end
    // drive interrupt remap over every code, then remap off
    for (int c = 0; c < 17; c++) begin
      wr(8'h63, (c < 16) ? {4'h0, c[3:0]} : 8'h83);
      drv = 1'b1;
      hit = c inside {[3:7], [9:12], 14, 15};
      cyc(2);
      chk_sig({direct, pic_irq}, {!hit, 16'h0028 | (hit ? 16'h1 << c : 16'h0)});
      drv = 1'b0;
    end
    // pin flag, active low then active high
    pin_in = 1'b0;
    cyc(2);
    rdc(8'h6a, 8'h01);
    chk_sig(ev, 17'h1);
    wr(8'h6a, 8'h00);
    rdc(8'h6a, 8'h01);
    wr(8'h6a, 8'h01);
    rdc(8'h6a, 8'h00);
    pin_in = 1'b1;
    wr(8'h64, 8'hc0);
    cyc(2);
    rdc(8'h6a, 8'h01);
    pin_in = 1'b0;
    cyc(2);
    wr(8'h6a, 8'h01);
    // debounce count 3: two ticks of 4 cycles
    wr(8'h64, 8'he3);
    pin_in = 1'b1;
    cyc(2);
    pin_in = 1'b0;
    cyc(16);
    rdc(8'h6a, 8'h00);
    pin_in = 1'b1;
    cyc(4);
    rdc(8'h6a, 8'h00);
    cyc(14);
    rdc(8'h6a, 8'h01);
    // i/o decode, input mode first
    wr(8'h66, 8'h30);
    wr(8'h67, 8'h12);
    u_host.io(1'b0, 1'b1, 16'h1230, 8'h00, q);
    chk_sig({oe_n, pin_out}, 17'h3);
    wr(8'h64, 8'h40);
    cyc(1);
    chk_sig(oe_n, 17'h0);
    for (int m = 0; m < 4; m++) begin
      wr(8'h66, {6'b001100, m[1:0]});
      msk = (m == 0) ? 16'h3 : (m == 1) ? 16'h7 : 16'hf;
      for (int k = 0; k < 4; k++) begin
        a = adr[k];
        hit = m != 2 && k != 3 && ((a ^ 16'h1230) & ~msk) == 16'h0;
        u_host.io(k[0], k != 3, a, 8'h00, q);
        chk_sig(pin_out, !hit);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
